// ---- src/sfw_erase_timer.sv ----
// self-timed erase duration counter with pause and failure capture
`timescale 1ns/100ps
`default_nettype none

module sfw_erase_timer (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic [31:0] len,
	input wire logic hold,
	input wire logic fault,
	// result
	output var logic done_q,
	output var logic fail_q
);

	logic [31:0] left_q;
	logic run_q;
	logic bad_q;
	logic last;

	assign last = run_q && !hold && !start && left_q == 32'h1;

	// ==================== countdown
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_q <= 32'h0;
			run_q <= 1'b0;
		end else if (start) begin
			left_q <= len;
			run_q <= 1'b1;
		end else if (run_q && !hold) begin
			left_q <= left_q - 32'h1;
			if (left_q == 32'h1) begin
				run_q <= 1'b0;
			end
		end
	end

	// ==================== failure is sticky for the whole run
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bad_q <= 1'b0;
		end else if (start) begin
			bad_q <= 1'b0;
		end else if (run_q && fault) begin
			bad_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			done_q <= last;
			fail_q <= last && (bad_q || fault);
		end
	end

	timer_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		done_q |-> $past(run_q) && !run_q) else $error("done without a run");

	timer_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		start |=> run_q && left_q == $past(len)) else $error("start not loaded");

endmodule

`default_nettype wire

// ---- src/sfw_pkg.sv ----
// shared constants and types for the serial flash write latch and erase sequencer
package sfw_pkg;

	// ==================== clock
	localparam int CLK_MHZ = 250;

	// ==================== command codes
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_SSE = 8'h20;
	localparam logic [7:0] CMD_SE = 8'hd8;
	localparam logic [7:0] CMD_DSE = 8'hc4;
	localparam logic [7:0] CMD_CLRF = 8'h50;
	localparam logic [7:0] CMD_SUSP = 8'h75;
	localparam logic [7:0] CMD_RESM = 8'h7a;

	// ==================== frame shape
	localparam logic [5:0] CMD_EDGES = 6'h08;
	localparam logic [5:0] FRAME_EDGES = 6'h20;
	localparam logic [5:0] EDGE_SAT = 6'h3f;
	localparam int SH_W = 128;
	localparam int ADDR_W = 26;

	// ==================== address alignment
	localparam logic [25:0] SUB_MASK = 26'h3fff000;
	localparam logic [25:0] SECT_MASK = 26'h3ff0000;
	localparam logic [25:0] DIE_MASK = 26'h2000000;
	localparam int DIE_BIT = 25;

	// ==================== flag status register
	localparam int FSR_READY = 7;
	localparam int FSR_ESUSP = 6;
	localparam int FSR_EERR = 5;
	localparam int FSR_PERR = 1;
	localparam logic [7:0] FSR_RST = 8'h80;

	// ==================== types
	typedef enum logic [1:0] {
		PROTO_EXT = 2'b00,
		PROTO_DUAL = 2'b01,
		PROTO_QUAD = 2'b10
	} sfw_proto_t;

	typedef enum logic [1:0] {
		KIND_SUB = 2'b00,
		KIND_SECT = 2'b01,
		KIND_DIE = 2'b10
	} sfw_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_ERASE = 2'b10,
		ST_SUSP = 2'b11
	} sfw_state_t;

endpackage

// ---- src/sfw_top.sv ----
// write enable latch and erase command sequencer of a serial nor flash
//
// Summary of operation
// - complete set command sets the latch
// - command uses one, two or four lanes
// - 06h sets latch, 04h clears latch
// - write-type commands need the latch set
// - unfinished set frame changes nothing
// - clear command resets latch; unfinished frame ignored
// - protection error: write disable keeps latch; only flag clear or an accepted erase resets it
// - ready flag low while erase runs
// - ready bit seven reports completion
// - subsector erase address selects aligned subsector
// - sector erase address selects aligned sector
// - address bits sampled on rising clock
// - erase starts only on select rising
// - latch clear: erase ignored, no flags
// - accepted erase clears the latch
// - erase timeout clears latch, sets error
// - unfinished erase frame changes nothing
// - protected erase refused, error bits set
// - die erase address selects whole die
// - die erase refused when the addressed die is locked
// - subsector and sector erase suspend, resume
`timescale 1ns/100ps
`default_nettype none

module sfw_top #(
	parameter int SSE_US = 50,
	parameter int SE_US = 500,
	parameter int DSE_US = 5000
) (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// link pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	// configuration and array answers
	input wire sfw_pkg::sfw_proto_t proto_mode,
	input wire logic [1:0] addr_hi,
	input wire logic sect_locked,
	input wire logic [1:0] die_locked,
	input wire logic erase_fault,
	// status
	output var logic wel_q,
	output var logic [7:0] fsr_q,
	output var logic erase_run_q,
	output var sfw_pkg::sfw_kind_t erase_kind_q,
	output var logic [25:0] erase_addr_q
);
	import sfw_pkg::*;

	localparam logic [31:0] SSE_CYC = 32'(SSE_US * CLK_MHZ);
	localparam logic [31:0] SE_CYC = 32'(SE_US * CLK_MHZ);
	localparam logic [31:0] DSE_CYC = 32'(DSE_US * CLK_MHZ);

	// ==================== reset release
	logic [1:0] rst_q;
	logic rst_s_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end

	assign rst_s_n = rst_q[1];

	// ==================== link side, clocked by the serial clock
	logic fresh_q;
	logic [5:0] lk_cnt_q;
	logic [SH_W-1:0] lk_sh_q;

	// select high re-arms the edge count without needing a serial clock edge
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			lk_cnt_q <= 6'h0;
		end else if (fresh_q) begin
			lk_cnt_q <= 6'h1;
		end else if (lk_cnt_q != EDGE_SAT) begin
			lk_cnt_q <= lk_cnt_q + 6'h1;
		end
	end

	// all four lanes are kept; the protocol picks lanes later
	always_ff @(posedge sck) begin
		lk_sh_q <= {lk_sh_q[SH_W-5:0], dq_in};
	end

	// ==================== frame end crossing
	// the serial clock is idle once select rises, so the shift and count words
	// are stable while the synchronised select edge lets this domain take them
	logic [2:0] cs_q;
	logic frame_end;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cs_q <= 3'h7;
		end else begin
			cs_q <= {cs_q[1:0], cs_n};
		end
	end

	assign frame_end = cs_q[1] && !cs_q[2];

	// ==================== lane assembly, newest edge in bit 0
	logic [31:0] word;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_lane
			always_comb begin
				unique case (proto_mode)
					PROTO_DUAL: word[gi] = lk_sh_q[4 * (gi / 2) + (gi % 2)];
					PROTO_QUAD: word[gi] = lk_sh_q[gi];
					default: word[gi] = lk_sh_q[4 * gi];
				endcase
			end
		end
	endgenerate

	logic fr_v_q;
	logic [5:0] fr_cnt_q;
	logic [31:0] fr_word_q;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			fr_v_q <= 1'b0;
			fr_cnt_q <= 6'h0;
			fr_word_q <= 32'h0;
		end else begin
			fr_v_q <= frame_end;
			if (frame_end) begin
				fr_cnt_q <= lk_cnt_q;
				fr_word_q <= word;
			end
		end
	end

	// ==================== decode
	// a frame counts only with exactly the right number of edges
	logic f_short;
	logic f_long;
	logic [7:0] cmd_s;
	logic [7:0] cmd_l;
	logic is_wren;
	logic is_wrdi;
	logic is_clrf;
	logic is_susp;
	logic is_resm;
	logic is_erase;
	sfw_kind_t f_kind;
	logic [25:0] f_addr;

	assign f_short = fr_v_q && fr_cnt_q == (CMD_EDGES >> proto_mode);
	assign f_long = fr_v_q && fr_cnt_q == (FRAME_EDGES >> proto_mode);
	assign cmd_s = fr_word_q[7:0];
	assign cmd_l = fr_word_q[31:24];
	assign is_wren = f_short && cmd_s == CMD_WREN;
	assign is_wrdi = f_short && cmd_s == CMD_WRDI;
	assign is_clrf = f_short && cmd_s == CMD_CLRF;
	assign is_susp = f_short && cmd_s == CMD_SUSP;
	assign is_resm = f_short && cmd_s == CMD_RESM;
	assign is_erase = f_long && (cmd_l == CMD_SSE || cmd_l == CMD_SE || cmd_l == CMD_DSE);
	assign f_addr = {addr_hi, fr_word_q[23:0]};

	always_comb begin
		unique case (cmd_l)
			CMD_SE: f_kind = KIND_SECT;
			CMD_DSE: f_kind = KIND_DIE;
			default: f_kind = KIND_SUB;
		endcase
	end

	// ==================== sequencer
	sfw_state_t state_q;
	logic lock_hit;
	logic busy;
	logic tmr_start;
	logic tmr_done;
	logic tmr_fail;
	logic [31:0] tmr_len;

	// lock inputs answer erase_addr_q combinationally in the check cycle
	assign lock_hit = (erase_kind_q == KIND_DIE) ?
		die_locked[erase_addr_q[DIE_BIT]] : sect_locked;
	assign busy = state_q == ST_CHECK || state_q == ST_ERASE;
	assign tmr_start = state_q == ST_CHECK && !lock_hit;

	always_comb begin
		unique case (erase_kind_q)
			KIND_SECT: tmr_len = SE_CYC;
			KIND_DIE: tmr_len = DSE_CYC;
			default: tmr_len = SSE_CYC;
		endcase
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			state_q <= ST_IDLE;
			erase_kind_q <= KIND_SUB;
			erase_addr_q <= 26'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (is_erase && wel_q) begin
						state_q <= ST_CHECK;
						erase_kind_q <= f_kind;
						unique case (f_kind)
							KIND_SECT: erase_addr_q <= f_addr & SECT_MASK;
							KIND_DIE: erase_addr_q <= f_addr & DIE_MASK;
							default: erase_addr_q <= f_addr & SUB_MASK;
						endcase
					end
				end
				ST_CHECK: begin
					state_q <= lock_hit ? ST_IDLE : ST_ERASE;
				end
				ST_ERASE: begin
					if (tmr_done) begin
						state_q <= ST_IDLE;
					end else if (is_susp && erase_kind_q != KIND_DIE) begin
						state_q <= ST_SUSP;
					end
				end
				ST_SUSP: begin
					// a suspend in the very last count lets the erase finish instead of hanging
					if (tmr_done || is_resm) begin
						state_q <= tmr_done ? ST_IDLE : ST_ERASE;
					end
				end
			endcase
		end
	end

	// the array is only driven while the erase actually runs
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			erase_run_q <= 1'b0;
		end else begin
			erase_run_q <= tmr_start || (state_q == ST_ERASE && !tmr_done && !is_susp) ||
				(state_q == ST_ERASE && erase_kind_q == KIND_DIE && !tmr_done) ||
				(state_q == ST_SUSP && is_resm && !tmr_done);
		end
	end

	sfw_erase_timer u_timer (
		.clk(clk),
		.rst_n(rst_s_n),
		.start(tmr_start),
		.len(tmr_len),
		.hold(state_q == ST_SUSP),
		.fault(erase_fault),
		.done_q(tmr_done),
		.fail_q(tmr_fail)
	);

	// ==================== write enable latch
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			wel_q <= 1'b0;
		end else if (is_wren && !busy) begin
			wel_q <= 1'b1;
		end else if (is_clrf) begin
			wel_q <= 1'b0;
		end else if (is_wrdi && !busy && !fsr_q[FSR_PERR]) begin
			wel_q <= 1'b0;
		end else if (tmr_start || tmr_done) begin
			wel_q <= 1'b0;
		end
	end

	// ==================== flag status register
	// clears are written first so a hardware set in the same cycle wins
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			fsr_q <= FSR_RST;
		end else begin
			if (is_clrf) begin
				fsr_q[FSR_EERR] <= 1'b0;
				fsr_q[FSR_PERR] <= 1'b0;
			end
			if (state_q == ST_CHECK && lock_hit) begin
				fsr_q[FSR_EERR] <= 1'b1;
				fsr_q[FSR_PERR] <= 1'b1;
			end
			if (tmr_start) begin
				fsr_q[FSR_READY] <= 1'b0;
			end
			if ((state_q == ST_ERASE || state_q == ST_SUSP) && tmr_done) begin
				fsr_q[FSR_READY] <= 1'b1;
				fsr_q[FSR_ESUSP] <= 1'b0;
				if (tmr_fail) begin
					fsr_q[FSR_EERR] <= 1'b1;
				end
			end else if (state_q == ST_ERASE && is_susp && erase_kind_q != KIND_DIE) begin
				fsr_q[FSR_ESUSP] <= 1'b1;
				fsr_q[FSR_READY] <= 1'b1;
			end
			if (state_q == ST_SUSP && is_resm && !tmr_done) begin
				fsr_q[FSR_ESUSP] <= 1'b0;
				fsr_q[FSR_READY] <= 1'b0;
			end
		end
	end

	// ==================== checks
	wren_set_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		is_wren && !busy |=> wel_q) else $error("latch not set");

	wrdi_clear_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		is_wrdi && !busy && !fsr_q[FSR_PERR] |=> !wel_q) else $error("latch not cleared");

	prot_keep_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		is_wrdi && fsr_q[FSR_PERR] && wel_q |=> wel_q) else $error("latch lost on error");

	partial_frame_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		fr_v_q && !f_short && !f_long && !busy && !tmr_done |=> $stable(wel_q) && $stable(fsr_q))
		else $error("partial frame acted");

	busy_flag_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		state_q == ST_ERASE |-> !fsr_q[FSR_READY]) else $error("ready during erase");

	no_latch_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		state_q == ST_IDLE && is_erase && !wel_q && !is_clrf |=> state_q == ST_IDLE && $stable(fsr_q))
		else $error("erase taken without latch");

	start_clear_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		state_q == ST_CHECK && !lock_hit |=> !wel_q && state_q == ST_ERASE && erase_run_q)
		else $error("erase start wrong");

	prot_refuse_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		state_q == ST_CHECK && lock_hit && wel_q |=> wel_q && fsr_q[FSR_PERR] && fsr_q[FSR_EERR]
		&& state_q == ST_IDLE) else $error("protected erase not refused");

	timeout_err_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		state_q == ST_ERASE && tmr_done && tmr_fail |=> fsr_q[FSR_EERR] && fsr_q[FSR_READY] && !wel_q)
		else $error("timeout not flagged");

	suspend_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		state_q == ST_ERASE && is_susp && !tmr_done && erase_kind_q != KIND_DIE |=>
		state_q == ST_SUSP && !erase_run_q && fsr_q[FSR_ESUSP] && fsr_q[FSR_READY])
		else $error("suspend failed");

	frame_lat_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		$rose(cs_q[2]) |-> fr_v_q) else $error("frame not delivered");

	run_origin_a: assert property (@(posedge clk) disable iff (!rst_s_n)
		$rose(erase_run_q) |-> $past(state_q == ST_CHECK || state_q == ST_SUSP))
		else $error("erase began outside a frame end");

endmodule

`default_nettype wire

// ---- tb/sfw_host_model.sv ----
// host side flash controller model driving select, serial clock and lanes
`timescale 1ns/100ps
`default_nettype none

module sfw_host_model (
	// link pins
	output var logic sck,
	output var logic cs_n,
	output var logic [3:0] dq_in
);
	localparam real HALF = 62.5;
	// a fractional skew keeps select edges off the system clock edges
	localparam real SKEW = 0.3;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		dq_in = 4'h0;
	end

	// ==================== frame
	// bits are left aligned and go out msb first; the clock stands still outside frames
	task automatic send(input logic [31:0] bits, input int edges, input int lanes);
		int k;
		#(SKEW);
		cs_n = 1'b0;
		for (int e = 0; e < edges; e++) begin
			for (int l = 0; l < lanes; l++) begin
				k = 31 - e * lanes - (lanes - 1 - l);
				dq_in[l] = bits[k];
			end
			#(HALF);
			sck = 1'b1;
			#(HALF);
			sck = 1'b0;
		end
		cs_n = 1'b1;
		// released lanes must not keep showing the last bits
		dq_in = ~dq_in;
		#(HALF);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the write latch and erase sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import sfw_pkg::*;

	typedef struct {sfw_proto_t p; int lanes; logic [7:0] code; logic wel;} sfw_row_t;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	sfw_proto_t proto_mode = PROTO_EXT;
	logic [1:0] addr_hi = 2'h0;
	logic [1:0] die_locked = 2'h0;
	logic erase_fault = 1'b0;
	logic lock_on = 1'b0;
	logic sect_locked;
	logic sck;
	logic cs_n;
	logic [3:0] dq_in;
	logic wel_q;
	logic [7:0] fsr_q;
	logic erase_run_q;
	sfw_kind_t erase_kind_q;
	logic [25:0] erase_addr_q;
	int mismatches = 0;
	int total_checks = 0;
	sfw_row_t rows [6] = '{'{PROTO_EXT, 1, CMD_WREN, 1'b1}, '{PROTO_EXT, 1, CMD_WRDI, 1'b0},
		'{PROTO_DUAL, 2, CMD_WREN, 1'b1}, '{PROTO_DUAL, 2, CMD_WRDI, 1'b0},
		'{PROTO_QUAD, 4, CMD_WREN, 1'b1}, '{PROTO_QUAD, 4, CMD_WRDI, 1'b0}};

	always #2 clk = ~clk;

	// the lock answer must follow the target address in the same cycle
	assign sect_locked = lock_on && (erase_addr_q[25:16] == 10'h112);

	sfw_host_model i_sfw_host_model (.sck(sck), .cs_n(cs_n), .dq_in(dq_in));

	// long erase times shortened; sector erase kept long enough to suspend it
	sfw_top #(.SSE_US(1), .SE_US(4), .DSE_US(1)) i_sfw_top (
		.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .dq_in(dq_in),
		.proto_mode(proto_mode), .addr_hi(addr_hi), .sect_locked(sect_locked),
		.die_locked(die_locked), .erase_fault(erase_fault), .wel_q(wel_q), .fsr_q(fsr_q),
		.erase_run_q(erase_run_q), .erase_kind_q(erase_kind_q), .erase_addr_q(erase_addr_q));

	// ==================== helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic settle();
		repeat (10) @(posedge clk);
	endtask

	task automatic cmd(input logic [7:0] code, input int lanes);
		i_sfw_host_model.send({code, 24'h0}, 8 / lanes, lanes);
		settle();
	endtask

	task automatic erase(input logic [7:0] code, input logic [23:0] addr, input int edges);
		i_sfw_host_model.send({code, addr}, edges, 1);
		settle();
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (fsr_q[7] !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("ready poll", {31'h0, fsr_q[7]}, 1);
		if (n >= 3000) begin
			stop_test();
		end
	endtask

	// ==================== sequence
	initial begin
		repeat (4) @(posedge clk);
		check("wel reset", wel_q, 0);
		check("fsr reset", fsr_q, 8'h80);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			@(posedge clk);
			proto_mode <= rows[i].p;
			repeat (4) @(posedge clk);
			cmd(rows[i].code, rows[i].lanes);
			check("wel row", wel_q, rows[i].wel);
		end
		@(posedge clk);
		proto_mode <= PROTO_EXT;
		repeat (4) @(posedge clk);
		i_sfw_host_model.send({CMD_WREN, 24'h0}, 7, 1);
		settle();
		check("wel short set", wel_q, 0);
		erase(CMD_SE, 24'h123456, 32);
		check("run no latch", erase_run_q, 0);
		check("fsr no latch", fsr_q, 8'h80);
		cmd(CMD_WREN, 1);
		i_sfw_host_model.send({CMD_WRDI, 24'h0}, 7, 1);
		settle();
		check("wel short clr", wel_q, 1);
		erase(CMD_SE, 24'h123456, 31);
		check("wel short erase", wel_q, 1);
		check("fsr short erase", fsr_q, 8'h80);
		@(posedge clk);
		addr_hi <= 2'h1;
		erase(CMD_SE, 24'h345678, 32);
		check("se addr", erase_addr_q, 26'h1340000);
		check("se kind", erase_kind_q, KIND_SECT);
		check("se run", erase_run_q, 1);
		check("se fsr", fsr_q, 8'h00);
		check("se wel", wel_q, 0);
		cmd(CMD_SUSP, 1);
		check("susp fsr", fsr_q, 8'hc0);
		check("susp run", erase_run_q, 0);
		cmd(CMD_RESM, 1);
		check("resm fsr", fsr_q, 8'h00);
		wait_ready();
		check("se done", fsr_q, 8'h80);
		cmd(CMD_WREN, 1);
		erase(CMD_SSE, 24'hfedcba, 32);
		check("sse addr", erase_addr_q, 26'h1fed000);
		check("sse kind", erase_kind_q, KIND_SUB);
		@(posedge clk);
		erase_fault <= 1'b1;
		@(posedge clk);
		erase_fault <= 1'b0;
		wait_ready();
		check("fault fsr", fsr_q, 8'ha0);
		check("fault wel", wel_q, 0);
		cmd(CMD_CLRF, 1);
		check("clrf fsr", fsr_q, 8'h80);
		@(posedge clk);
		lock_on <= 1'b1;
		cmd(CMD_WREN, 1);
		erase(CMD_SE, 24'h12ffff, 32);
		check("prot fsr", fsr_q, 8'ha2);
		check("prot wel", wel_q, 1);
		check("prot run", erase_run_q, 0);
		cmd(CMD_WRDI, 1);
		check("prot wrdi", wel_q, 1);
		cmd(CMD_CLRF, 1);
		check("clrf wel", wel_q, 0);
		@(posedge clk);
		addr_hi <= 2'h2;
		die_locked <= 2'h2;
		cmd(CMD_WREN, 1);
		erase(CMD_DSE, 24'h000100, 32);
		check("die lock fsr", fsr_q, 8'ha2);
		check("die lock wel", wel_q, 1);
		cmd(CMD_CLRF, 1);
		@(posedge clk);
		die_locked <= 2'h1;
		cmd(CMD_WREN, 1);
		erase(CMD_DSE, 24'h000100, 32);
		check("die addr", erase_addr_q, 26'h2000000);
		check("die kind", erase_kind_q, KIND_DIE);
		wait_ready();
		check("die wel", wel_q, 0);
		// reset in the middle of an erase must drop everything back to idle
		cmd(CMD_WREN, 1);
		erase(CMD_SSE, 24'h000000, 32);
		check("rst pre run", erase_run_q, 1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		check("rst run", erase_run_q, 0);
		check("rst wel", wel_q, 0);
		check("rst fsr", fsr_q, 8'h80);
		rst_n <= 1'b1;
		repeat (2) begin
			@(posedge clk);
			check("rel wel", wel_q, 0);
			check("rel fsr", fsr_q, 8'h80);
			check("rel run", erase_run_q, 0);
		end
		repeat (4) @(posedge clk);
		cmd(CMD_WREN, 1);
		check("rel set", wel_q, 1);
		stop_test();
	end
endmodule
`default_nettype wire
